//--- scp_device.sv
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module scp_device
	import scp_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	// Link to the controller.
	scp_link_if.dev         link,
	// Status.
	output scp_pwr_t        pwr_state_out,
	output logic [3:0]      bank_busy_out,
	output logic            burst_active_out,
	output logic            refresh_out,
	output logic [11:0]     mode_out
);
	// Registered state.
	scp_pwr_t   pwr_q, pwr_d;
	scp_bank_t  bank_q [BANKS];
	scp_bank_t  bank_d [BANKS];
	logic [7:0] bcnt_q [BANKS];
	logic [7:0] bcnt_d [BANKS];
	logic       prior_clock_enable_q;
	logic [11:0] mode_q, mode_d;
	logic [8:0] left_q, left_d;
	logic [7:0] beat_q, beat_d;
	logic [7:0] col_q, col_d;
	logic [1:0] bbank_q, bbank_d;
	logic       brd_q, brd_d;
	logic       bap_q, bap_d;
	logic [1:0] rp_v_q, rp_v_d;
	logic [15:0] rp0_q, rp0_d;
	logic [15:0] rp1_q, rp1_d;
	logic [15:0] dq_out_q, dq_out_d;
	logic       dq_oe_q, dq_oe_d;
	logic [3:0] busy_q, busy_d;
	logic       refresh_q, refresh_d;
	logic       burst_q, burst_d;
	logic [15:0] mem [MEM_WORDS];

	// Decode and access signals.
	scp_op_t    op;
	logic [1:0] sel_bank;
	logic       run;
	logic       cmd_ok;
	logic       all_idle;
	logic       any_open;
	logic [8:0] len;
	logic       full;
	logic [7:0] mask;
	logic       interleave;
	logic       cl3;
	logic       acc_v;
	logic       acc_rd;
	logic [1:0] acc_bank;
	logic [7:0] acc_col;
	logic       last;
	logic       ap_now;
	logic       hit;
	logic [5:0] widx;

	// Command decode from the strobes; deselect is a NOP with chip select high.
	always_comb begin
		sel_bank = {link.bank_select_hi, link.bank_select_lo};
		if (link.chip_sel_n) begin
			op = OP_DESEL;
		end else begin
			case ({link.row_strobe_n, link.col_strobe_n, link.write_en_n})
				3'h3:    op = OP_ACT;
				3'h5:    op = OP_READ;
				3'h4:    op = OP_WRITE;
				3'h2:    op = OP_PRE;
				3'h0:    op = OP_MRS;
				3'h6:    op = OP_BST;
				3'h1:    op = link.clk_en ? OP_REF : OP_SELF;
				default: op = OP_NOP;
			endcase
		end
		run    = (pwr_q == PW_RUN);
		cmd_ok = run && prior_clock_enable_q;
	end

	// Burst shape taken from the programmed mode.
	always_comb begin
		len        = scp_burst_len(mode_q[MR_BL_LSB +: 3]);
		full       = (mode_q[MR_BL_LSB +: 3] == BL_FULL);
		mask       = 8'(len - 9'h001);
		interleave = mode_q[MR_BT_BIT] && !full;
		cl3        = (mode_q[MR_CL_LSB +: 3] == CL_3);
		all_idle   = 1'b1;
		any_open   = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			if (bank_q[i] != BK_IDLE) begin
				all_idle = 1'b0;
			end
			if (bank_q[i] == BK_ACTIVE || bank_q[i] == BK_AUTOPRE) begin
				any_open = 1'b1;
			end
		end
	end

	// Next state of burst engine, banks, mode, power and read pipe.
	always_comb begin
		pwr_d     = pwr_q;
		mode_d    = mode_q;
		left_d    = left_q;
		beat_d    = beat_q;
		col_d     = col_q;
		bbank_d   = bbank_q;
		brd_d     = brd_q;
		bap_d     = bap_q;
		rp_v_d    = rp_v_q;
		rp0_d     = rp0_q;
		rp1_d     = rp1_q;
		dq_out_d  = dq_out_q;
		dq_oe_d   = dq_oe_q;
		refresh_d = 1'b0;
		acc_v     = 1'b0;
		acc_rd    = brd_q;
		acc_bank  = bbank_q;
		acc_col   = col_q;
		last      = 1'b0;
		ap_now    = bap_q;
		hit       = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			bank_d[i] = bank_q[i];
			bcnt_d[i] = bcnt_q[i];
		end
		// A new read or write replaces any running burst at once.
		if (cmd_ok && (op == OP_READ || op == OP_WRITE) && bank_q[sel_bank] == BK_ACTIVE) begin
			acc_v    = 1'b1;
			acc_rd   = (op == OP_READ);
			acc_bank = sel_bank;
			acc_col  = link.addr[COL_W-1:0];
			col_d    = link.addr[COL_W-1:0];
			beat_d   = 8'h01;
			bbank_d  = sel_bank;
			brd_d    = (op == OP_READ);
			bap_d    = link.addr[PRECHARGE_FLAG_ADDR_BIT] && !full;
			ap_now   = bap_d;
			left_d   = full ? 9'h001 : len - 9'h001;
			last     = (len == 9'h001);
		end else if (run && left_q != 9'h000) begin
			// NOP and deselect fall through here and leave the burst going.
			acc_v   = 1'b1;
			acc_col = interleave ? (col_q ^ beat_q) : ((col_q & ~mask) | ((col_q + beat_q) & mask));
			beat_d  = beat_q + 8'h01;
			left_d  = full ? left_q : left_q - 9'h001;
			last    = (left_q == 9'h001) && !full;
		end
		if (cmd_ok && op == OP_BST) begin
			left_d = 9'h000;
		end
		if (cmd_ok && op == OP_PRE && (link.addr[PRECHARGE_FLAG_ADDR_BIT] || sel_bank == bbank_q)) begin
			left_d = 9'h000;
		end
		if (cmd_ok && op == OP_MRS && all_idle) begin
			mode_d = link.addr;
		end
		refresh_d = cmd_ok && op == OP_REF && all_idle;
		// Bank timers keep running in power down so a precharge finishes on time.
		if (pwr_q != PW_SUSPEND) begin
			for (int i = 0; i < BANKS; i++) begin
				hit = cmd_ok && op == OP_PRE && (link.addr[PRECHARGE_FLAG_ADDR_BIT] || sel_bank == 2'(i));
				case (bank_q[i])
					BK_IDLE: begin
						if (cmd_ok && op == OP_ACT && sel_bank == 2'(i)) begin
							bank_d[i] = BK_ACTIVE;
						end
					end
					BK_ACTIVE: begin
						if (hit) begin
							bank_d[i] = BK_PRECH;
							bcnt_d[i] = PRECHARGE_CYC;
						end else if (acc_v && last && ap_now && acc_bank == 2'(i)) begin
							// A read closes as its last beat issues, latency minus one before its last data.
							bank_d[i] = acc_rd ? BK_PRECH : BK_AUTOPRE;
							bcnt_d[i] = acc_rd ? PRECHARGE_CYC : WRITE_RECOVERY_CYC;
						end
					end
					BK_AUTOPRE: begin
						if (bcnt_q[i] == 8'h01) begin
							bank_d[i] = BK_PRECH;
							bcnt_d[i] = PRECHARGE_CYC;
						end else begin
							bcnt_d[i] = bcnt_q[i] - 8'h01;
						end
					end
					BK_PRECH: begin
						if (bcnt_q[i] == 8'h01) begin
							bank_d[i] = BK_IDLE;
						end else begin
							bcnt_d[i] = bcnt_q[i] - 8'h01;
						end
					end
					default: bank_d[i] = BK_IDLE;
				endcase
			end
		end
		// Power state: clock enable low is seen here, the freeze starts one edge later.
		case (pwr_q)
			PW_RUN: begin
				if (prior_clock_enable_q && !link.clk_en) begin
					if (op == OP_SELF && all_idle) begin
						pwr_d = PW_SELF;
					end else if (any_open || left_q != 9'h000) begin
						pwr_d = PW_SUSPEND;
					end else begin
						pwr_d = PW_DOWN;
					end
				end
			end
			PW_SUSPEND, PW_DOWN, PW_SELF: begin
				// Only the clock enable is looked at while stopped.
				if (link.clk_en) begin
					pwr_d = PW_RUN;
				end
			end
			default: pwr_d = PW_RUN;
		endcase
		// Read pipe; it freezes with the rest of the clocked operation.
		if (run) begin
			rp_v_d   = {rp_v_q[0], acc_v && acc_rd && !link.dqm};
			rp0_d    = mem[{acc_bank, acc_col[MEM_COL_BITS-1:0]}];
			rp1_d    = rp0_q;
			dq_out_d = cl3 ? rp1_q : rp0_q;
			dq_oe_d  = cl3 ? rp_v_q[1] : rp_v_q[0];
		end
		busy_d  = 4'h0;
		for (int i = 0; i < BANKS; i++) begin
			busy_d[i] = (bank_d[i] != BK_IDLE);
		end
		burst_d = (left_d != 9'h000);
	end

	// State registers.
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pwr_q                <= PW_RUN;
			prior_clock_enable_q <= 1'b0;
			mode_q               <= MODE_RESET;
			left_q               <= 9'h000;
			beat_q               <= 8'h00;
			col_q                <= 8'h00;
			bbank_q              <= 2'h0;
			brd_q                <= 1'b0;
			bap_q                <= 1'b0;
			rp_v_q               <= 2'h0;
			rp0_q                <= 16'h0000;
			rp1_q                <= 16'h0000;
			dq_out_q             <= 16'h0000;
			dq_oe_q              <= 1'b0;
			busy_q               <= 4'h0;
			refresh_q            <= 1'b0;
			burst_q              <= 1'b0;
			for (int i = 0; i < BANKS; i++) begin
				bank_q[i] <= BK_IDLE;
				bcnt_q[i] <= 8'h00;
			end
		end else begin
			pwr_q                <= pwr_d;
			prior_clock_enable_q <= link.clk_en;
			mode_q               <= mode_d;
			left_q               <= left_d;
			beat_q               <= beat_d;
			col_q                <= col_d;
			bbank_q              <= bbank_d;
			brd_q                <= brd_d;
			bap_q                <= bap_d;
			rp_v_q               <= rp_v_d;
			rp0_q                <= rp0_d;
			rp1_q                <= rp1_d;
			dq_out_q             <= dq_out_d;
			dq_oe_q              <= dq_oe_d;
			busy_q               <= busy_d;
			refresh_q            <= refresh_d;
			burst_q              <= burst_d;
			for (int i = 0; i < BANKS; i++) begin
				bank_q[i] <= bank_d[i];
				bcnt_q[i] <= bcnt_d[i];
			end
		end
	end

	// Cell storage; only the low column bits are kept, so addresses alias.
	assign widx = {acc_bank, acc_col[MEM_COL_BITS-1:0]};
	always_ff @(posedge clk_sys_in) begin
		if (acc_v && !acc_rd && !link.dqm) begin
			mem[widx] <= link.dq;
		end
	end

	// Outputs straight from the registers.
	assign link.dq_d        = dq_out_q;
	assign link.dq_d_oe     = dq_oe_q;
	assign pwr_state_out    = pwr_q;
	assign bank_busy_out    = busy_q;
	assign burst_active_out = burst_q;
	assign refresh_out      = refresh_q;
	assign mode_out         = mode_q;
endmodule : scp_device

//--- scp_pkg.sv
package scp_pkg;
	// Clock rate and the printed timing figures.
	localparam int CLK_PERIOD_NS                  = 40;
	localparam int PRECHARGE_TIME_NS              = 15;
	localparam int ACTIVE_TO_PRECHARGE_TIME_NS    = 42;
	localparam int REFRESH_CYCLE_NS               = 60;
	localparam int CLOCK_ENABLE_SETUP_TIME_NS     = 10;
	localparam int SELF_REFRESH_EXIT_NS           = 80;

	// Minimum times rounded up to whole clock cycles; the clock enable hold takes one cycle more.
	localparam logic [7:0] PRECHARGE_CYC  = 8'((PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] ACT_PRE_CYC    = 8'((ACTIVE_TO_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] REFRESH_CYC    = 8'((REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CKE_HOLD_CYC   = 8'((CLOCK_ENABLE_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
	localparam logic [7:0] SELF_EXIT_CYC  = 8'((SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MODE_SET_CYC   = 8'h02;
	localparam logic [7:0] WRITE_RECOVERY_CYC    = 8'h02;
	localparam logic [7:0] DATA_IN_TO_ACTIVE_CYC = WRITE_RECOVERY_CYC + PRECHARGE_CYC;

	// Link widths and address fields.
	localparam int BANKS                   = 4;
	localparam int ADDR_W                  = 12;
	localparam int COL_W                   = 8;
	localparam int DQ_W                    = 16;
	localparam int PRECHARGE_FLAG_ADDR_BIT = 10;
	localparam int MEM_COL_BITS            = 4;
	localparam int MEM_WORDS               = 64;

	// Mode register layout and reset value.
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam logic [2:0]  BL_1      = 3'h0;
	localparam logic [2:0]  BL_2      = 3'h1;
	localparam logic [2:0]  BL_4      = 3'h2;
	localparam logic [2:0]  BL_8      = 3'h3;
	localparam logic [2:0]  BL_FULL   = 3'h7;
	localparam logic [2:0]  CL_3      = 3'h3;
	localparam logic [11:0] MODE_RESET = 12'h032;

	// Controller register map on APB.
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_CTRL   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_BANK_LSB = 4;
	localparam int CMD_ADDR_LSB = 8;
	localparam int WD_DQM_BIT   = 16;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_ERR_BIT   = 1;
	localparam int ST_RVAL_BIT  = 2;
	localparam int ST_CKE_BIT   = 3;
	localparam logic CKE_RESET  = 1'b1;

	// Commands, bank states and power states.
	typedef enum logic [3:0] {OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_MRS, OP_BST,
		OP_REF, OP_SELF, OP_DESEL} scp_op_t;
	typedef enum logic [2:0] {BK_IDLE, BK_ACTIVE, BK_AUTOPRE, BK_PRECH} scp_bank_t;
	typedef enum logic [1:0] {PW_RUN, PW_SUSPEND, PW_DOWN, PW_SELF} scp_pwr_t;

	// Burst length in beats for a mode register code.
	function automatic logic [8:0] scp_burst_len(input logic [2:0] code);
		case (code)
			BL_1:    return 9'h001;
			BL_2:    return 9'h002;
			BL_4:    return 9'h004;
			BL_8:    return 9'h008;
			BL_FULL: return 9'h100;
			default: return 9'h001;
		endcase
	endfunction : scp_burst_len
endpackage : scp_pkg

//--- scp_link_if.sv
`timescale 1ns/1ns
interface scp_link_if;
	// Command pins; chip select and the three strobes are active low, the clock enable and dqm active high.
	logic        chip_sel_n;
	logic        row_strobe_n;
	logic        col_strobe_n;
	logic        write_en_n;
	logic        clk_en;
	logic        dqm;
	logic        bank_select_lo;
	logic        bank_select_hi;
	logic [11:0] addr;
	// Data bus, driven by either end.
	logic [15:0] dq_h;
	logic        dq_h_oe;
	logic [15:0] dq_d;
	logic        dq_d_oe;
	logic [15:0] dq;

	// The device wins a clash so a bad schedule shows up as corrupt write data.
	assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 16'h0000);

	modport ctrl (output chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, clk_en, dqm,
		bank_select_lo, bank_select_hi, addr, dq_h, dq_h_oe, input dq, dq_d_oe);
	modport dev (input chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, clk_en, dqm,
		bank_select_lo, bank_select_hi, addr, dq, dq_h_oe, output dq_d, dq_d_oe);
endinterface : scp_link_if

//--- scp_ctrl.sv
`timescale 1ns/1ns
module scp_ctrl
	import scp_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	// APB slave.
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Link to the device.
	scp_link_if.ctrl         link
);
	// Registered state.
	logic [2:0]  pin_q, pin_d;
	logic        cs_n_q, cs_n_d;
	logic        cke_q, cke_d;
	logic        self_q, self_d;
	logic [1:0]  bank_q, bank_d;
	logic [11:0] addr_q, addr_d;
	logic [16:0] wdata_q, wdata_d;
	logic        dq_oe_q, dq_oe_d;
	logic [7:0]  wbeats_q, wbeats_d;
	logic [7:0]  busy_q, busy_d;
	logic [2:0]  mbl_q, mbl_d;
	logic        err_q, err_d;
	logic [15:0] rdata_q, rdata_d;
	logic        rval_q, rval_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;

	// Decoded request fields.
	logic        take;
	logic        stall;
	logic        mapped;
	scp_op_t     op_w;
	logic [11:0] ad_w;
	logic [8:0]  len;

	// Bus answer, command issue and pin timing.
	always_comb begin
		take   = psel_in && penable_in && pready_q;
		mapped = (paddr_in == REG_CMD) || (paddr_in == REG_CTRL) || (paddr_in == REG_WDATA) ||
			(paddr_in == REG_STATUS) || (paddr_in == REG_RDATA);
		// Command and clock enable writes wait until the last spacing is met.
		stall  = pwrite_in && (paddr_in == REG_CMD || paddr_in == REG_CTRL) && busy_q != 8'h00;
		op_w   = scp_op_t'(pwdata_in[CMD_OP_LSB +: 4]);
		ad_w   = pwdata_in[CMD_ADDR_LSB +: ADDR_W];
		len    = scp_burst_len(mbl_q);
		pready_d  = psel_in && penable_in && !pready_q && !stall;
		pslverr_d = pready_d && !mapped;
		case (paddr_in)
			REG_CMD:    prdata_d = {12'h000, addr_q, 2'h0, bank_q, 4'h0};
			REG_CTRL:   prdata_d = {31'h00000000, cke_q};
			REG_WDATA:  prdata_d = {15'h0000, wdata_q};
			REG_STATUS: prdata_d = {28'h0000000, cke_q, rval_q, err_q, busy_q != 8'h00};
			REG_RDATA:  prdata_d = {16'h0000, rdata_q};
			default:    prdata_d = 32'h00000000;
		endcase
		// Between commands the pins idle as NOP, which also covers power down exit.
		pin_d    = 3'h7;
		cs_n_d   = 1'b0;
		bank_d   = bank_q;
		addr_d   = addr_q;
		cke_d    = cke_q;
		self_d   = self_q;
		wdata_d  = wdata_q;
		mbl_d    = mbl_q;
		err_d    = err_q;
		rval_d   = rval_q;
		rdata_d  = rdata_q;
		busy_d   = (busy_q != 8'h00) ? busy_q - 8'h01 : 8'h00;
		dq_oe_d  = (wbeats_q != 8'h00);
		wbeats_d = (wbeats_q != 8'h00) ? wbeats_q - 8'h01 : 8'h00;
		if (take && pwrite_in && paddr_in == REG_WDATA) begin
			wdata_d = pwdata_in[WD_DQM_BIT:0];
		end
		if (take && pwrite_in && paddr_in == REG_STATUS && pwdata_in[ST_ERR_BIT]) begin
			err_d = 1'b0;
		end
		if (take && !pwrite_in && paddr_in == REG_RDATA) begin
			rval_d = 1'b0;
		end
		if (take && pwrite_in && paddr_in == REG_CTRL) begin
			cke_d = pwdata_in[0];
			if (pwdata_in[0] && !cke_q) begin
				// Clock enable stays high and only NOPs go out for the exit time.
				busy_d = self_q ? SELF_EXIT_CYC : CKE_HOLD_CYC;
				self_d = 1'b0;
			end
		end
		if (take && pwrite_in && paddr_in == REG_CMD) begin
			bank_d = pwdata_in[CMD_BANK_LSB +: 2];
			addr_d = ad_w;
			busy_d = 8'h01;
			if ((op_w == OP_READ || op_w == OP_WRITE) && ad_w[PRECHARGE_FLAG_ADDR_BIT] && mbl_q == BL_FULL) begin
				err_d = 1'b1;
			end else begin
				case (op_w)
					OP_ACT: begin
						pin_d  = 3'h3;
						busy_d = ACT_PRE_CYC;
					end
					OP_READ, OP_WRITE: begin
						pin_d = (op_w == OP_READ) ? 3'h5 : 3'h4;
						if (ad_w[PRECHARGE_FLAG_ADDR_BIT]) begin
							busy_d = 8'(len) + DATA_IN_TO_ACTIVE_CYC;
						end
						if (op_w == OP_WRITE) begin
							dq_oe_d  = 1'b1;
							wbeats_d = (mbl_q == BL_FULL) ? 8'h00 : 8'(len - 9'h001);
						end
					end
					OP_PRE: begin
						pin_d  = 3'h2;
						busy_d = PRECHARGE_CYC;
					end
					OP_MRS: begin
						pin_d  = 3'h0;
						mbl_d  = ad_w[MR_BL_LSB +: 3];
						busy_d = MODE_SET_CYC;
					end
					OP_BST: pin_d = 3'h6;
					OP_REF: begin
						pin_d  = 3'h1;
						busy_d = REFRESH_CYC;
					end
					OP_SELF: begin
						// Software has idled every bank and run any refresh burst first.
						pin_d  = 3'h1;
						cke_d  = 1'b0;
						self_d = 1'b1;
					end
					OP_DESEL: cs_n_d = 1'b1;
					default:  pin_d = 3'h7;
				endcase
			end
		end
		// Capture wins over a clear in the same cycle.
		if (link.dq_d_oe) begin
			rdata_d = link.dq;
			rval_d  = 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_q     <= 3'h7;
			cs_n_q    <= 1'b1;
			cke_q     <= CKE_RESET;
			self_q    <= 1'b0;
			bank_q    <= 2'h0;
			addr_q    <= 12'h000;
			wdata_q   <= 17'h00000;
			dq_oe_q   <= 1'b0;
			wbeats_q  <= 8'h00;
			busy_q    <= 8'h00;
			mbl_q     <= MODE_RESET[MR_BL_LSB +: 3];
			err_q     <= 1'b0;
			rdata_q   <= 16'h0000;
			rval_q    <= 1'b0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pin_q     <= pin_d;
			cs_n_q    <= cs_n_d;
			cke_q     <= cke_d;
			self_q    <= self_d;
			bank_q    <= bank_d;
			addr_q    <= addr_d;
			wdata_q   <= wdata_d;
			dq_oe_q   <= dq_oe_d;
			wbeats_q  <= wbeats_d;
			busy_q    <= busy_d;
			mbl_q     <= mbl_d;
			err_q     <= err_d;
			rdata_q   <= rdata_d;
			rval_q    <= rval_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// Pins and bus answer straight from the registers.
	assign link.chip_sel_n     = cs_n_q;
	assign link.row_strobe_n   = pin_q[2];
	assign link.col_strobe_n   = pin_q[1];
	assign link.write_en_n     = pin_q[0];
	assign link.clk_en         = cke_q;
	assign link.bank_select_lo = bank_q[0];
	assign link.bank_select_hi = bank_q[1];
	assign link.addr           = addr_q;
	assign link.dqm            = wdata_q[WD_DQM_BIT];
	assign link.dq_h           = wdata_q[15:0];
	assign link.dq_h_oe        = dq_oe_q;
	assign prdata_out          = prdata_q;
	assign pready_out          = pready_q;
	assign pslverr_out         = pslverr_q;
endmodule : scp_ctrl

//--- scp_link_monitor.sv
`timescale 1ns/1ns
module scp_link_monitor
	import scp_pkg::*;
(
	// Clock and reset.
	input wire logic        clk_sys_in,
	input wire logic        reset_n_in,
	// Link pins.
	input wire logic        chip_sel_n,
	input wire logic        row_strobe_n,
	input wire logic        col_strobe_n,
	input wire logic        write_en_n,
	input wire logic        clk_en,
	input wire logic [11:0] addr,
	input wire logic        dq_h_oe,
	input wire logic [15:0] dq_d,
	input wire logic        dq_d_oe
);
	// Command decode from the strobes.
	wire logic rd  = !chip_sel_n && row_strobe_n && !col_strobe_n && write_en_n;
	wire logic wr  = !chip_sel_n && row_strobe_n && !col_strobe_n && !write_en_n;
	wire logic pre = !chip_sel_n && !row_strobe_n && col_strobe_n && !write_en_n;
	wire logic act = !chip_sel_n && !row_strobe_n && col_strobe_n && write_en_n;
	wire logic nop = row_strobe_n && col_strobe_n && write_en_n;

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	// Read data starts three clocks after a decoded read.
	chk_read_lat: assert property (rd && clk_en && $past(clk_en) |-> ##3 dq_d_oe)
		else $error("read data late");
	// A command stands one cycle, then the pins fall back to no-operation.
	chk_cmd_pulse: assert property (!chip_sel_n && !nop && clk_en |=> nop)
		else $error("command held too long");
	// Nothing may cut into an auto-precharge burst or reopen its bank early.
	chk_ap_quiet: assert property ((rd || wr) && addr[PRECHARGE_FLAG_ADDR_BIT] |=> !(rd || wr || pre || act) [*3])
		else $error("command during auto-precharge");
	// The first write beat goes out with the command.
	chk_wr_beat: assert property (wr |-> dq_h_oe)
		else $error("write data missing");
	// Only one end drives the data bus.
	chk_no_clash: assert property (!(dq_h_oe && dq_d_oe))
		else $error("data bus clash");
	// Suspend freezes the read output, which must hold rather than vanish.
	chk_frozen: assert property (!clk_en && !$past(clk_en) && dq_d_oe |=> dq_d_oe && $stable(dq_d))
		else $error("output moved in suspend");
	// The burst moves again two clocks after clock enable returns.
	chk_resume: assert property ($rose(clk_en) && dq_d_oe |=> $stable(dq_d) ##1 !$stable(dq_d))
		else $error("resume timing wrong");
	// Leaving a stop, clock enable stays high with no-operation for two clocks.
	chk_exit_nop: assert property ($rose(clk_en) |-> (clk_en && nop) [*2])
		else $error("exit without no-operation");
	// Main scenarios.
	cov_ap: cover property (rd && addr[PRECHARGE_FLAG_ADDR_BIT]);
	cov_susp: cover property (!clk_en && dq_d_oe);
	cov_resume: cover property ($rose(clk_en) && dq_d_oe);
endmodule : scp_link_monitor

//--- test_sdram_command_power_control.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_sdram_command_power_control
	import scp_pkg::*;
;
	// Bench signals; the ones the bench drives are given a value at time zero.
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        perr;
	scp_pwr_t    pstate;
	logic [3:0]  busy;
	logic [11:0] mode;
	logic        burst;
	logic        refr;
	logic [31:0] rdat;
	logic        rerr;
	logic [15:0] q[$];
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          refs = 0;
	int          cyc = 0;

	scp_link_if scp_link_if_i ();
	scp_ctrl scp_ctrl_i (.clk_sys_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(perr), .link(scp_link_if_i.ctrl));
	scp_device scp_device_i (.clk_sys_in(clk), .reset_n_in(rst_n), .link(scp_link_if_i.dev),
		.pwr_state_out(pstate), .bank_busy_out(busy), .burst_active_out(burst), .refresh_out(refr), .mode_out(mode));
	scp_link_monitor scp_link_monitor_i (.clk_sys_in(clk), .reset_n_in(rst_n),
		.chip_sel_n(scp_link_if_i.chip_sel_n), .row_strobe_n(scp_link_if_i.row_strobe_n),
		.col_strobe_n(scp_link_if_i.col_strobe_n), .write_en_n(scp_link_if_i.write_en_n),
		.clk_en(scp_link_if_i.clk_en), .addr(scp_link_if_i.addr), .dq_h_oe(scp_link_if_i.dq_h_oe),
		.dq_d(scp_link_if_i.dq_d), .dq_d_oe(scp_link_if_i.dq_d_oe));

	// Clock of 40 ns.
	always #20 clk = !clk;

	// Count refresh pulses and cut a hang short.
	always @(posedge clk) begin
		cyc++;
		if (refr === 1'h1) refs++;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end

	// One APB transfer; the slave may stall, so no cycle count is assumed.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = perr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb

	task automatic cmd(input scp_op_t op, input logic [1:0] bk, input logic [11:0] ad);
		apb(1'h1, REG_CMD, {12'h000, ad, 2'h0, bk, op});
	endtask : cmd

	// Write the clock enable, then let it reach the device and its status settle.
	task automatic cke(input logic v);
		apb(1'h1, REG_CTRL, {31'h0, v});
		repeat (4) @(negedge clk);
	endtask : cke

	// Single writes with auto-precharge, then interleaved reads of lengths 2, 4 and 8.
	task automatic t_bursts();
		cmd(OP_MRS, 2'h0, 12'h030);
		for (int c = 0; c < 8; c++) begin
			cmd(OP_ACT, 2'h0, 12'h000);
			apb(1'h1, REG_WDATA, 32'h00a0 + c);
			cmd(OP_WRITE, 2'h0, 12'h400 + 12'(c));
		end
		for (int k = 1; k < 4; k++) begin
			cmd(OP_MRS, 2'h0, 12'h038 + 12'(k));
			cmd(OP_ACT, 2'h0, 12'h000);
			`CHK("mode", 12'h038 + 12'(k), mode)
			cmd(OP_READ, 2'h0, 12'h405);
			q = {};
			repeat (14) begin
				@(negedge clk);
				if (scp_link_if_i.dq_d_oe === 1'h1) q.push_back(scp_link_if_i.dq_d);
			end
			`CHK("beats", 1 << k, q.size())
			foreach (q[i]) `CHK("beat", 16'h00a0 + 16'(5 ^ i), q[i])
		end
		apb(1'h0, REG_RDATA, 32'h0);
		`CHK("rdata", 16'h00a2, rdat[15:0])
		apb(1'h0, 8'h20, 32'h0);
		`CHK("slverr", 1'h1, rerr)
	endtask : t_bursts

	// Precharge of one bank, then of all banks.
	task automatic t_banks();
		cmd(OP_ACT, 2'h1, 12'h000);
		cmd(OP_ACT, 2'h2, 12'h000);
		cmd(OP_PRE, 2'h1, 12'h000);
		repeat (4) @(negedge clk);
		`CHK("banks", 4'h4, busy)
		cmd(OP_PRE, 2'h0, 12'h400);
		repeat (4) @(negedge clk);
		`CHK("banks", 4'h0, busy)
	endtask : t_banks

	// Full page: refused auto-precharge, burst stop, then the earlier mode is restored.
	task automatic t_full();
		cmd(OP_MRS, 2'h0, 12'h037);
		cmd(OP_READ, 2'h0, 12'h400);
		apb(1'h0, REG_STATUS, 32'h0);
		`CHK("err", 1'h1, rdat[ST_ERR_BIT])
		apb(1'h1, REG_STATUS, 32'h2);
		apb(1'h0, REG_STATUS, 32'h0);
		`CHK("err", 1'h0, rdat[ST_ERR_BIT])
		cmd(OP_ACT, 2'h0, 12'h000);
		cmd(OP_READ, 2'h0, 12'h000);
		repeat (8) @(negedge clk);
		`CHK("burst", 1'h1, burst)
		cmd(OP_BST, 2'h0, 12'h000);
		repeat (4) @(negedge clk);
		`CHK("burst", 1'h0, burst)
		cmd(OP_PRE, 2'h0, 12'h400);
		cmd(OP_MRS, 2'h0, 12'h03b);
	endtask : t_full

	// Power down, refresh, self refresh and clock suspend with and without a burst.
	task automatic t_power();
		cke(1'h0);
		`CHK("pwr", PW_DOWN, pstate)
		cke(1'h1);
		cmd(OP_REF, 2'h0, 12'h000);
		repeat (4) @(negedge clk);
		`CHK("refresh", 1, refs)
		cmd(OP_SELF, 2'h0, 12'h000);
		repeat (4) @(negedge clk);
		`CHK("pwr", PW_SELF, pstate)
		cke(1'h1);
		`CHK("pwr", PW_RUN, pstate)
		cmd(OP_ACT, 2'h0, 12'h000);
		cke(1'h0);
		`CHK("pwr", PW_SUSPEND, pstate)
		cke(1'h1);
		cmd(OP_READ, 2'h0, 12'h000);
		cke(1'h0);
		`CHK("pwr", PW_SUSPEND, pstate)
		`CHK("burst", 1'h1, burst)
		cke(1'h1);
		`CHK("pwr", PW_RUN, pstate)
		repeat (4) @(negedge clk);
		`CHK("burst", 1'h0, burst)
	endtask : t_power

	task automatic stop_test();
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test

	// Reset for ten clocks, then the scenarios in turn.
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		t_bursts();
		t_banks();
		t_full();
		t_power();
		stop_test();
	end
endmodule : test_sdram_command_power_control
